// File: design/cpg_defs.svh
`ifndef CPG_DEFS_SVH
`define CPG_DEFS_SVH

// clock and timing
`define CPG_CLK_PERIOD_NS 25
`define CPG_BLINK_TICK_NS 1000000
`define CPG_BLINK_TICK_CYC ((`CPG_BLINK_TICK_NS) / (`CPG_CLK_PERIOD_NS))

// transport and transfer limits
`define CPG_I2C_ADDR 7'h2c
`define CPG_MAX_XFER_BYTES 6'h3c
`define CPG_RD_FLAG_BIT 7

// command register space (7-bit pointer)
`define CPG_REG_IN_STATE 7'h00
`define CPG_REG_EVT_STATUS 7'h01
`define CPG_REG_EVT_RISE_EN 7'h02
`define CPG_REG_EVT_FALL_EN 7'h03
`define CPG_REG_IRQ_EN 7'h04
`define CPG_REG_OUT_LEVEL 7'h05
`define CPG_REG_PWM_EN 7'h06
`define CPG_REG_BLINK_EN 7'h07
`define CPG_REG_BLINK_PERIOD 7'h08
`define CPG_REG_DUTY0 7'h10
`define CPG_REG_TRANSPORT 7'h18
`define CPG_REG_EXP_IN 7'h19
`define CPG_REG_EXP_OUT 7'h1a

// outputs and reset values
`define CPG_NUM_GEN_OUT 5
`define CPG_GEN_OUT_INT 2
`define CPG_OUT_LEVEL_RST 5'h00
`define CPG_GEN_OUT_RST 5'h04
`define CPG_BLINK_PERIOD_RST 8'hfa
`define CPG_DUTY_RST 8'h80
`define CPG_SYNC_RST 14'h001c

`endif

// File: design/cpg_pkg.sv
package cpg_pkg;
  // which host transport carries commands
  typedef enum logic [1:0] {
    CPG_TP_USB = 2'h0,
    CPG_TP_I2C = 2'h1,
    CPG_TP_SPI = 2'h2
  } cpg_transport_t;

  // i2c slave states, gray along idle-addr-ack-write-ack-read-ack
  typedef enum logic [2:0] {
    I2C_IDLE = 3'b000,
    I2C_ADDR = 3'b001,
    I2C_AACK = 3'b011,
    I2C_WBYTE = 3'b010,
    I2C_WACK = 3'b110,
    I2C_RBYTE = 3'b111,
    I2C_RACK = 3'b101
  } cpg_i2c_st_t;
endpackage

// File: design/cpg_link_if.sv
`timescale 1ns/1ps
// byte exchange between the spi clock domain and the system domain
interface cpg_link_if;
  logic [7:0] rx_byte; // last byte shifted in, held for a byte time
  logic rx_tgl; // flips once per received byte
  logic [7:0] tx_byte; // next byte to shift out, quasi-static
  logic miso; // serial data toward the host
  modport link (output rx_byte, output rx_tgl, output miso, input tx_byte);
  modport core (input rx_byte, input rx_tgl, input miso, output tx_byte);
endinterface

// File: design/cpg_spi_link.sv
`timescale 1ns/1ps
`include "cpg_defs.svh"
// spi slave shifter, mode 0, msb first, runs only on the host clock
module cpg_spi_link (
  // link pins
  input wire logic spi_clk_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_mosi_i,
  // system reset, only used for the received byte and its toggle
  input wire logic resetn_i,
  // byte carrier toward the core
  cpg_link_if.link lnk
);
  logic [2:0] bit_cnt_r; // bit position within the byte
  logic [6:0] rx_sh_r; // incoming bits so far
  logic [7:0] tx_sh_r; // outgoing bits
  logic [7:0] rx_byte_r; // completed byte
  logic rx_tgl_r; // byte event toggle

  // chip select ends the frame: the clock may stop, so it resets asynchronously
  always_ff @(posedge spi_clk_i or posedge spi_cs_n_i) begin
    if (spi_cs_n_i) begin
      bit_cnt_r <= 3'h0;
      rx_sh_r <= 7'h00;
    end else begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      rx_sh_r <= {rx_sh_r[5:0], spi_mosi_i};
    end
  end

  // tx_byte was settled by the core a few system cycles after the previous byte ended, so sampling it here is safe
  always_ff @(posedge spi_clk_i or posedge spi_cs_n_i) begin
    if (spi_cs_n_i) begin
      tx_sh_r <= 8'h00;
    end else if (bit_cnt_r == 3'h7) begin
      tx_sh_r <= lnk.tx_byte;
    end else begin
      tx_sh_r <= {tx_sh_r[6:0], 1'b0};
    end
  end

  // the toggle must survive frame ends, so only the system reset clears it
  always_ff @(posedge spi_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_byte_r <= 8'h00;
      rx_tgl_r <= 1'b0;
    end else if (!spi_cs_n_i && bit_cnt_r == 3'h7) begin
      rx_byte_r <= {rx_sh_r, spi_mosi_i};
      rx_tgl_r <= ~rx_tgl_r;
    end
  end

  assign lnk.rx_byte = rx_byte_r;
  assign lnk.rx_tgl = rx_tgl_r;
  assign lnk.miso = tx_sh_r[7];

  a_spi_byte_event: assert property (@(posedge spi_clk_i) disable iff (!resetn_i || spi_cs_n_i)
    bit_cnt_r == 3'h7 |=> rx_tgl_r != $past(rx_tgl_r))
    else $error("spi byte end did not flip the toggle");
endmodule

// File: design/cpg_top.sv
`timescale 1ns/1ps
`include "cpg_defs.svh"
module cpg_top import cpg_pkg::*; #(
  parameter cpg_transport_t TRANSPORT = CPG_TP_I2C,
  parameter int BLINK_TICK_CYC = `CPG_BLINK_TICK_CYC,
  parameter bit EXP_EN = 1'b1
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // spi control link
  input wire logic spi_clk_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  // i2c control link, open drain data
  input wire logic i2c_scl_i,
  input wire logic i2c_sda_i,
  output logic i2c_sda_o,
  output logic i2c_sda_oe_o,
  // endpoint zero requests from the usb core
  input wire logic ep0_req_i,
  input wire logic ep0_rd_i,
  input wire logic [6:0] ep0_addr_i,
  input wire logic [7:0] ep0_wdata_i,
  output logic ep0_ack_o,
  output logic [7:0] ep0_rdata_o,
  // general inputs: bit 0 mute button, bit 1 action button
  input wire logic [1:0] general_input_i,
  // general outputs
  output logic codec_reset_out_o,
  output logic mic_topology_select_o,
  output logic int_n_o,
  output logic red_led_out_o,
  output logic green_led_out_o,
  // expander pins carried as gpio
  input wire logic [7:0] exp_in_i,
  output logic [7:0] exp_out_o
);
  localparam int TW = $clog2(BLINK_TICK_CYC);

  if (BLINK_TICK_CYC < 2) begin : g_bad_tick
    $error("blink tick must be at least two cycles");
  end

  cpg_link_if lnk ();

  cpg_spi_link u_spi (
    .spi_clk_i(spi_clk_i),
    .spi_cs_n_i(spi_cs_n_i),
    .spi_mosi_i(spi_mosi_i),
    .resetn_i(resetn_i),
    .lnk(lnk.link)
  );

  // synchronisers for the button, i2c, chip select and expander pins and the spi byte toggle
  logic [13:0] sync1_r, sync2_r, prev_r;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1_r <= `CPG_SYNC_RST;
      sync2_r <= `CPG_SYNC_RST;
      prev_r <= `CPG_SYNC_RST;
    end else begin
      sync1_r <= {exp_in_i, lnk.rx_tgl, spi_cs_n_i, i2c_sda_i, i2c_scl_i, general_input_i};
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  logic [1:0] btn_s, btn_p;
  logic scl_s, scl_p, sda_s, sda_p, cs_s, cs_p, tgl_s, tgl_p;
  assign {tgl_s, cs_s, sda_s, scl_s, btn_s} = sync2_r[5:0];
  assign {tgl_p, cs_p, sda_p, scl_p, btn_p} = prev_r[5:0];

  // i2c bus conditions
  logic scl_rise, scl_fall, i2c_start, i2c_stop;
  assign scl_rise = scl_s & ~scl_p;
  assign scl_fall = ~scl_s & scl_p;
  assign i2c_start = (TRANSPORT == CPG_TP_I2C) & scl_s & scl_p & sda_p & ~sda_s;
  assign i2c_stop = scl_s & scl_p & ~sda_p & sda_s;

  // i2c slave state
  cpg_i2c_st_t i2c_st_r;
  logic [3:0] i2c_cnt_r; // bits seen in this byte
  logic [7:0] i2c_sh_r; // shift register
  logic i2c_rw_r, i2c_sda_oe_r, i2c_sda_r;

  // command engine state shared by the i2c and spi transports
  logic [5:0] idx_r; // bytes of this transfer
  logic [6:0] ptr_r; // register pointer, auto increments
  logic rd_mode_r; // spi frame is a read
  logic [7:0] rdata_r; // fetched read byte
  logic spi_fetch_r;
  logic accept;
  assign accept = idx_r < `CPG_MAX_XFER_BYTES;

  // front end strobes, one transport live by construction
  logic addr_done, addr_match, i2c_wr_stb, i2c_fetch, spi_byte_stb;
  logic cmd_start, cmd_wr_stb, cmd_fetch;
  logic [7:0] cmd_byte;
  assign addr_done = (i2c_st_r == I2C_ADDR) && scl_fall && (i2c_cnt_r == 4'h8);
  assign addr_match = i2c_sh_r[7:1] == `CPG_I2C_ADDR;
  assign i2c_wr_stb = (i2c_st_r == I2C_WBYTE) && scl_fall && (i2c_cnt_r == 4'h8);
  assign i2c_fetch = (addr_done && addr_match && i2c_sh_r[0]) ||
                     ((i2c_st_r == I2C_RACK) && scl_rise && !sda_s);
  assign spi_byte_stb = (TRANSPORT == CPG_TP_SPI) && (tgl_s != tgl_p);
  assign cmd_start = i2c_start || ((TRANSPORT == CPG_TP_SPI) && cs_p && !cs_s);
  assign cmd_wr_stb = i2c_wr_stb || spi_byte_stb;
  assign cmd_byte = (TRANSPORT == CPG_TP_SPI) ? lnk.rx_byte : i2c_sh_r;
  assign cmd_fetch = i2c_fetch || spi_fetch_r;

  // i2c slave: samples on scl rise, changes sda after scl fall
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      i2c_st_r <= I2C_IDLE;
      i2c_cnt_r <= 4'h0;
      i2c_sh_r <= 8'h00;
      i2c_rw_r <= 1'b0;
      i2c_sda_oe_r <= 1'b0;
    end else if (i2c_start) begin
      i2c_st_r <= I2C_ADDR;
      i2c_cnt_r <= 4'h0;
      i2c_sda_oe_r <= 1'b0;
    end else if (i2c_stop) begin
      i2c_st_r <= I2C_IDLE;
      i2c_sda_oe_r <= 1'b0;
    end else begin
      case (i2c_st_r)
        I2C_ADDR, I2C_WBYTE: begin
          if (scl_rise) begin
            i2c_sh_r <= {i2c_sh_r[6:0], sda_s};
            i2c_cnt_r <= i2c_cnt_r + 4'h1;
          end else if (addr_done) begin
            // other addresses are ignored until the next start
            i2c_st_r <= addr_match ? I2C_AACK : I2C_IDLE;
            i2c_sda_oe_r <= addr_match;
            i2c_rw_r <= i2c_sh_r[0];
          end else if (i2c_wr_stb) begin
            i2c_st_r <= I2C_WACK;
            i2c_sda_oe_r <= accept;
          end
        end
        I2C_AACK, I2C_RACK: begin
          if (i2c_st_r == I2C_RACK && scl_rise && sda_s) begin
            i2c_st_r <= I2C_IDLE; // host nack ends the read
          end else if (scl_fall) begin
            i2c_cnt_r <= 4'h0;
            if (i2c_st_r == I2C_RACK || i2c_rw_r) begin
              i2c_st_r <= I2C_RBYTE;
              i2c_sh_r <= rdata_r;
              i2c_sda_oe_r <= ~rdata_r[7];
            end else begin
              i2c_st_r <= I2C_WBYTE;
              i2c_sda_oe_r <= 1'b0;
            end
          end
        end
        I2C_WACK: begin
          if (scl_fall) begin
            i2c_st_r <= I2C_WBYTE;
            i2c_cnt_r <= 4'h0;
            i2c_sda_oe_r <= 1'b0;
          end
        end
        I2C_RBYTE: begin
          if (scl_rise) begin
            i2c_cnt_r <= i2c_cnt_r + 4'h1;
          end else if (scl_fall && i2c_cnt_r == 4'h8) begin
            i2c_st_r <= I2C_RACK;
            i2c_sda_oe_r <= 1'b0;
          end else if (scl_fall) begin
            i2c_sh_r <= {i2c_sh_r[6:0], 1'b0};
            i2c_sda_oe_r <= ~i2c_sh_r[6];
          end
        end
        default: begin
          i2c_sda_oe_r <= 1'b0;
        end
      endcase
    end
  end

  // open drain: the data level is always low, only the enable moves
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      i2c_sda_r <= 1'b0;
    end else begin
      i2c_sda_r <= 1'b0;
    end
  end

  // configuration registers
  logic [1:0] evt_status_r, evt_rise_en_r, evt_fall_en_r, irq_en_r;
  logic [4:0] out_level_r, pwm_en_r, blink_en_r, gen_out_r, gen_out_nxt;
  logic [7:0] blink_period_r, exp_out_r, pwm_cnt_r, blink_cnt_r;
  logic [7:0] duty_r [`CPG_NUM_GEN_OUT];
  logic blink_phase_r, blink_tick;
  logic [TW-1:0] tick_cnt_r;

  function automatic logic duty_hit(input logic [6:0] a);
    duty_hit = (a >= `CPG_REG_DUTY0) && (a < `CPG_REG_DUTY0 + 7'(`CPG_NUM_GEN_OUT));
  endfunction

  function automatic logic is_mapped(input logic [6:0] a);
    case (a)
      `CPG_REG_IN_STATE, `CPG_REG_EVT_STATUS, `CPG_REG_EVT_RISE_EN, `CPG_REG_EVT_FALL_EN,
      `CPG_REG_IRQ_EN, `CPG_REG_OUT_LEVEL, `CPG_REG_PWM_EN, `CPG_REG_BLINK_EN,
      `CPG_REG_BLINK_PERIOD, `CPG_REG_TRANSPORT: is_mapped = 1'b1;
      `CPG_REG_EXP_IN, `CPG_REG_EXP_OUT: is_mapped = EXP_EN;
      default: is_mapped = duty_hit(a);
    endcase
  endfunction

  // one read decode for every transport; unmapped reads give zero
  function automatic logic [7:0] reg_read(input logic [6:0] a);
    case (a)
      `CPG_REG_IN_STATE: reg_read = {6'h00, btn_s};
      `CPG_REG_EVT_STATUS: reg_read = {6'h00, evt_status_r};
      `CPG_REG_EVT_RISE_EN: reg_read = {6'h00, evt_rise_en_r};
      `CPG_REG_EVT_FALL_EN: reg_read = {6'h00, evt_fall_en_r};
      `CPG_REG_IRQ_EN: reg_read = {6'h00, irq_en_r};
      `CPG_REG_OUT_LEVEL: reg_read = {3'h0, out_level_r};
      `CPG_REG_PWM_EN: reg_read = {3'h0, pwm_en_r};
      `CPG_REG_BLINK_EN: reg_read = {3'h0, blink_en_r};
      `CPG_REG_BLINK_PERIOD: reg_read = blink_period_r;
      `CPG_REG_TRANSPORT: reg_read = {6'h00, TRANSPORT};
      `CPG_REG_EXP_IN: reg_read = EXP_EN ? sync2_r[13:6] : 8'h00;
      `CPG_REG_EXP_OUT: reg_read = exp_out_r;
      default: reg_read = duty_hit(a) ? duty_r[3'(a - `CPG_REG_DUTY0)] : 8'h00;
    endcase
  endfunction

  // shared register write port
  logic reg_we, ep0_live;
  logic [6:0] reg_waddr;
  logic [7:0] reg_wdata;
  assign ep0_live = (TRANSPORT == CPG_TP_USB) && ep0_req_i;
  assign reg_we = (cmd_wr_stb && accept && idx_r != 6'h00 && !rd_mode_r) ||
                  (ep0_live && !ep0_rd_i);
  assign reg_waddr = ep0_live ? ep0_addr_i : ptr_r;
  assign reg_wdata = ep0_live ? ep0_wdata_i : cmd_byte;

  // transfer bookkeeping: first byte is the pointer, bit 7 marks an spi read
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      idx_r <= 6'h00;
      ptr_r <= 7'h00;
      rd_mode_r <= 1'b0;
      rdata_r <= 8'h00;
      spi_fetch_r <= 1'b0;
    end else begin
      spi_fetch_r <= spi_byte_stb &&
                     (idx_r == 6'h00 ? lnk.rx_byte[`CPG_RD_FLAG_BIT] : rd_mode_r);
      if (cmd_start) begin
        idx_r <= 6'h00;
        rd_mode_r <= 1'b0;
      end else if (cmd_wr_stb && accept) begin
        idx_r <= idx_r + 6'h01;
        if (idx_r == 6'h00) begin
          ptr_r <= cmd_byte[6:0];
          rd_mode_r <= (TRANSPORT == CPG_TP_SPI) && cmd_byte[`CPG_RD_FLAG_BIT];
        end else if (!rd_mode_r) begin
          ptr_r <= ptr_r + 7'h01;
        end
      end else if (cmd_fetch && accept) begin
        rdata_r <= reg_read(ptr_r);
        ptr_r <= ptr_r + 7'h01;
        if (TRANSPORT == CPG_TP_I2C) begin
          idx_r <= idx_r + 6'h01;
        end
      end
    end
  end
  assign lnk.tx_byte = rdata_r;

  // register writes; unmapped addresses change nothing
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      evt_rise_en_r <= 2'h0;
      evt_fall_en_r <= 2'h0;
      irq_en_r <= 2'h0;
      out_level_r <= `CPG_OUT_LEVEL_RST;
      pwm_en_r <= 5'h00;
      blink_en_r <= 5'h00;
      blink_period_r <= `CPG_BLINK_PERIOD_RST;
      exp_out_r <= 8'h00;
      for (int i = 0; i < `CPG_NUM_GEN_OUT; i++) begin
        duty_r[i] <= `CPG_DUTY_RST;
      end
    end else if (reg_we) begin
      case (reg_waddr)
        `CPG_REG_EVT_RISE_EN: evt_rise_en_r <= reg_wdata[1:0];
        `CPG_REG_EVT_FALL_EN: evt_fall_en_r <= reg_wdata[1:0];
        `CPG_REG_IRQ_EN: irq_en_r <= reg_wdata[1:0];
        `CPG_REG_OUT_LEVEL: out_level_r <= reg_wdata[4:0];
        `CPG_REG_PWM_EN: pwm_en_r <= reg_wdata[4:0];
        `CPG_REG_BLINK_EN: blink_en_r <= reg_wdata[4:0];
        `CPG_REG_BLINK_PERIOD: blink_period_r <= reg_wdata;
        `CPG_REG_EXP_OUT: begin
          if (EXP_EN) begin
            exp_out_r <= reg_wdata;
          end
        end
        default: begin
          if (duty_hit(reg_waddr)) begin
            duty_r[3'(reg_waddr - `CPG_REG_DUTY0)] <= reg_wdata;
          end
        end
      endcase
    end
  end

  // edge events are sticky; a new edge beats a write-one clear
  logic [1:0] evt_set, evt_clr;
  assign evt_set = (btn_s & ~btn_p & evt_rise_en_r) | (~btn_s & btn_p & evt_fall_en_r);
  assign evt_clr = (reg_we && reg_waddr == `CPG_REG_EVT_STATUS) ? reg_wdata[1:0] : 2'h0;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      evt_status_r <= 2'h0;
    end else begin
      evt_status_r <= (evt_status_r & ~evt_clr) | evt_set;
    end
  end

  // pwm ramp and blink timebase
  assign blink_tick = tick_cnt_r == TW'(BLINK_TICK_CYC - 1);
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pwm_cnt_r <= 8'h00;
      tick_cnt_r <= '0;
      blink_cnt_r <= 8'h00;
      blink_phase_r <= 1'b1;
    end else begin
      pwm_cnt_r <= pwm_cnt_r + 8'h01;
      tick_cnt_r <= blink_tick ? '0 : tick_cnt_r + TW'(1);
      if (blink_tick) begin
        if (blink_cnt_r + 8'h01 >= blink_period_r) begin
          blink_cnt_r <= 8'h00;
          blink_phase_r <= ~blink_phase_r;
        end else begin
          blink_cnt_r <= blink_cnt_r + 8'h01;
        end
      end
    end
  end

  // output shaping; the interrupt slot follows pending events only
  for (genvar g = 0; g < `CPG_NUM_GEN_OUT; g++) begin : g_gen_out
    if (g == `CPG_GEN_OUT_INT) begin : g_int
      assign gen_out_nxt[g] = ~|(evt_status_r & irq_en_r);
    end else begin : g_pin
      assign gen_out_nxt[g] = out_level_r[g] & (~pwm_en_r[g] | (pwm_cnt_r < duty_r[g])) &
                          (~blink_en_r[g] | blink_phase_r);
    end
  end

  // outputs and endpoint zero answers, all registered
  logic ep0_ack_r;
  logic [7:0] ep0_rdata_r;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gen_out_r <= `CPG_GEN_OUT_RST;
      ep0_ack_r <= 1'b0;
      ep0_rdata_r <= 8'h00;
    end else begin
      gen_out_r <= gen_out_nxt;
      ep0_ack_r <= ep0_live;
      if (ep0_live && ep0_rd_i) begin
        ep0_rdata_r <= reg_read(ep0_addr_i);
      end
    end
  end

  assign {green_led_out_o, red_led_out_o, int_n_o, mic_topology_select_o,
          codec_reset_out_o} = gen_out_r;
  assign exp_out_o = exp_out_r;
  assign ep0_ack_o = ep0_ack_r;
  assign ep0_rdata_o = ep0_rdata_r;
  assign i2c_sda_o = i2c_sda_r;
  assign i2c_sda_oe_o = i2c_sda_oe_r;
  assign spi_miso_o = lnk.miso;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_rise0;
    btn_s[0] && !btn_p[0] && evt_rise_en_r[0];
  endsequence
  sequence s_addr_seen;
    addr_done ##0 addr_match;
  endsequence

  a_edge_sets_event: assert property (s_rise0 |=> evt_status_r[0])
    else $error("enabled rising edge did not set the event");
  a_event_stays_set: assert property (evt_status_r[1] && !evt_clr[1] |=> evt_status_r[1])
    else $error("event cleared without a clear write");
  a_int_low_pending: assert property (|(evt_status_r & irq_en_r) |=> !int_n_o)
    else $error("interrupt not low while an event is pending");
  a_int_high_idle: assert property (!(|(evt_status_r & irq_en_r)) |=> int_n_o)
    else $error("interrupt low with nothing pending");
  a_plain_level_out: assert property (!pwm_en_r[0] && !blink_en_r[0] |=>
    codec_reset_out_o == $past(out_level_r[0]))
    else $error("plain output does not follow its level");
  a_unmapped_inert: assert property (reg_we && !is_mapped(reg_waddr) |=>
    $stable(out_level_r) && $stable(irq_en_r) && $stable(blink_period_r))
    else $error("write to an unmapped address changed state");
  a_xfer_limit: assert property (idx_r <= `CPG_MAX_XFER_BYTES)
    else $error("transfer byte count beyond limit");
  a_addr_ack: assert property (s_addr_seen |=> i2c_sda_oe_o && i2c_st_r == I2C_AACK)
    else $error("own address not acknowledged");
  a_addr_ignore: assert property (addr_done && !addr_match |=>
    !i2c_sda_oe_o && i2c_st_r == I2C_IDLE)
    else $error("foreign address answered");
  a_single_transport: assert property (TRANSPORT != CPG_TP_I2C |->
    !i2c_sda_oe_o ##1 !i2c_sda_oe_o)
    else $error("inactive i2c transport drove the bus");
  // back to back requests keep the answer high, so compare with the request one cycle back
  a_ep0_answer: assert property (ep0_live |=> ep0_ack_o ##1 ep0_ack_o == $past(ep0_live))
    else $error("endpoint zero request not answered in one cycle");
endmodule

// File: dv/cpg_spi_host.sv
`timescale 1ns/1ps
// spi host: mode 0, msb first, clock stands low between frames
module cpg_spi_host (
  // pins toward the device
  output logic spi_clk_o,
  output logic spi_cs_n_o,
  output logic spi_mosi_o,
  input wire logic spi_miso_i
);
  initial begin
    spi_clk_o = 1'b0;
    spi_cs_n_o = 1'b1;
    spi_mosi_o = 1'b0;
  end
  // one byte at 64 ns a bit; miso taken just before the rise that it serves
  task automatic xfer_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      spi_mosi_o = tx[i];
      #32;
      rx[i] = spi_miso_i;
      spi_clk_o = 1'b1;
      #32;
      spi_clk_o = 1'b0;
    end
  endtask
  // pointer byte, one data or dummy byte, optional third byte read back
  task automatic frame(input logic [7:0] b0, input logic [7:0] b1, input int n,
                       output logic [7:0] last);
    logic [7:0] r;
    spi_cs_n_o = 1'b0;
    #40;
    xfer_byte(b0, r);
    xfer_byte(b1, r);
    if (n > 2) begin
      xfer_byte(8'h00, r);
    end
    last = r;
    #32;
    spi_cs_n_o = 1'b1;
    // released line shows no stale level
    spi_mosi_o = ~spi_mosi_o;
    // gap well above 4 system cycles
    #200;
  endtask
endmodule

// File: dv/cpg_top_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("BAD %0t mismatch got %0h exp %0h", $time, a, b); end end
module cpg_top_tb import cpg_pkg::*;;
  logic sys_clk, resetn, scl, miso, cs_n, mosi, ep_req, ep_rd, ack, sda, sda_oe;
  logic codec, mic, int_n, red, green;
  logic [1:0] gin;
  logic [6:0] ep_addr;
  logic [7:0] ep_wd, ep_rd_d, exp_in, exp_out, rv;
  int error_cnt = 0;
  int n_checks = 0;
  // spi build; short blink tick keeps runs short
  cpg_top #(.TRANSPORT(CPG_TP_SPI), .BLINK_TICK_CYC(4)) dut_u (
    .sys_clk_i(sys_clk), .resetn_i(resetn), .spi_clk_i(scl), .spi_cs_n_i(cs_n),
    .spi_mosi_i(mosi), .spi_miso_o(miso), .i2c_scl_i(1'b1), .i2c_sda_i(1'b1),
    .i2c_sda_o(sda), .i2c_sda_oe_o(sda_oe), .ep0_req_i(ep_req), .ep0_rd_i(ep_rd),
    .ep0_addr_i(ep_addr), .ep0_wdata_i(ep_wd), .ep0_ack_o(ack), .ep0_rdata_o(ep_rd_d),
    .general_input_i(gin), .codec_reset_out_o(codec), .mic_topology_select_o(mic),
    .int_n_o(int_n), .red_led_out_o(red), .green_led_out_o(green), .exp_in_i(exp_in),
    .exp_out_o(exp_out));
  cpg_spi_host host_u (.spi_clk_o(scl), .spi_cs_n_o(cs_n), .spi_mosi_o(mosi),
    .spi_miso_i(miso));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // write then let the byte cross into the system domain
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    host_u.frame(p, d, 2, rv);
    cyc(12);
  endtask
  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    host_u.frame(p | 8'h80, 8'h00, 3, d);
  endtask
  // bounded wait for the interrupt pin to reach a level
  task automatic wait_int(input logic lvl);
    int k;
    for (k = 0; k < 40 && int_n !== lvl; k++) cyc(1);
    if (k == 40) begin
      error_cnt++;
      $display("BAD %0t interrupt wait ran out", $time);
      wrap_up();
    end
  endtask
  task automatic t_reset;
    `CHK({codec, mic, red, green, int_n}, 5'h01)
    `CHK(exp_out, 8'h00)
  endtask
  // endpoint zero idle in an spi build; transport readable over spi
  task automatic t_transport;
    int acks;
    acks = 0;
    ep_rd = 1'b1;
    ep_addr = 7'h18;
    ep_req = 1'b1;
    cyc(1);
    ep_req = 1'b0;
    repeat (6) begin
      cyc(1);
      acks += (ack === 1'b1);
    end
    `CHK(acks, 0)
    `CHK(ep_rd_d, 8'h00)
    `CHK({sda, sda_oe}, 2'b00)
    rd(8'h18, rv);
    `CHK(rv, 8'h02)
  endtask
  // all outputs set; unmapped write leaves them alone
  task automatic t_outputs;
    wr(8'h05, 8'h1f);
    `CHK({codec, mic, red, green, int_n}, 5'h1f)
    wr(8'h7f, 8'h00);
    `CHK({codec, mic, red, green}, 4'hf)
    rd(8'h7f, rv);
    `CHK(rv, 8'h00)
  endtask
  task automatic t_input;
    gin = 2'b10;
    cyc(6);
    rd(8'h00, rv);
    `CHK(rv, 8'h02)
  endtask
  // rise on mute raises the interrupt; disabled fall on action does not
  task automatic t_event;
    wr(8'h02, 8'h01);
    wr(8'h04, 8'h01);
    gin = 2'b01;
    wait_int(1'b0);
    `CHK(int_n, 1'b0)
    rd(8'h01, rv);
    `CHK(rv, 8'h01)
    wr(8'h01, 8'h01);
    wait_int(1'b1);
    `CHK(int_n, 1'b1)
  endtask
  // quarter duty on output 0 over one full pwm count
  task automatic t_pwm;
    int hi;
    hi = 0;
    wr(8'h10, 8'h40);
    wr(8'h06, 8'h01);
    repeat (256) begin
      cyc(1);
      hi += (codec === 1'b1);
    end
    `CHK(hi, 64)
  endtask
  // output 1 blinks with a two tick half period: on for 32 of any 64 cycles
  task automatic t_blink;
    int hi;
    hi = 0;
    wr(8'h08, 8'h02);
    wr(8'h07, 8'h02);
    repeat (64) begin
      cyc(1);
      hi += (mic === 1'b1);
    end
    `CHK(hi, 32)
  endtask
  // mid-run reset brings the five general outputs and the expander outputs back to their reset levels
  task automatic t_rerun;
    resetn = 1'b0;
    cyc(3);
    resetn = 1'b1;
    cyc(3);
    t_reset();
  endtask
  task automatic t_exp;
    exp_in = 8'h3c;
    wr(8'h1a, 8'ha5);
    `CHK(exp_out, 8'ha5)
    rd(8'h19, rv);
    `CHK(rv, 8'h3c)
  endtask
  initial begin
    resetn = 1'b0;
    gin = 2'b00;
    exp_in = 8'h00;
    ep_req = 1'b0;
    ep_rd = 1'b0;
    ep_addr = 7'h00;
    ep_wd = 8'h00;
    cyc(3);
    resetn = 1'b1;
    cyc(3);
    t_reset();
    t_transport();
    t_outputs();
    t_input();
    t_event();
    t_pwm();
    t_blink();
    t_exp();
    t_rerun();
    wrap_up();
  end
endmodule
